/* File: hdl/rdl_params.svh */
// Purpose: Constants for the redriver control block: register map,
//          field positions, reset values and timing figures.
// Assumes: Byte addresses on a 32-bit Avalon-MM register bus.
// Notes:   Definitions only; included by bare name.
`ifndef RDL_PARAMS_SVH
`define RDL_PARAMS_SVH

// ----------------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------------
`define RDL_OFS_CTRL        5'h00
`define RDL_OFS_EQ          5'h04
`define RDL_OFS_SWING       5'h08
`define RDL_OFS_STATUS      5'h0C

// ----------------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------------
`define RDL_CTRL_CFG_LSB    0
`define RDL_CTRL_LIM_BIT    2
`define RDL_CTRL_PRE_BIT    3
`define RDL_CTRL_DEE_BIT    4
`define RDL_CTRL_RST        5'h00

// ----------------------------------------------------------------------
// Equalization register: four 4-bit lane fields, lane 0 lowest
// ----------------------------------------------------------------------
`define RDL_EQ_W            4
`define RDL_EQ_RST          16'h0000

// ----------------------------------------------------------------------
// Swing register fields, each two bits wide
// ----------------------------------------------------------------------
`define RDL_SW_DN_LSB       0
`define RDL_SW_UPLIN_LSB    2
`define RDL_SW_LIM_LSB      4
`define RDL_SW_PRE_LSB      6
`define RDL_SW_DEE_LSB      8
`define RDL_SW_RST          10'h00F
`define RDL_SWING_LEVEL_THREE 2'h3

// ----------------------------------------------------------------------
// Status register fields
// ----------------------------------------------------------------------
`define RDL_ST_LINK_LSB     0
`define RDL_ST_USB_BIT      2
`define RDL_ST_REGMODE_BIT  3
`define RDL_ST_RATE_BIT     4
`define RDL_ST_LIM_BIT      5
`define RDL_ST_STRAP_LSB    8

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define RDL_CLK_MHZ         25
`define RDL_RXDET_PERIOD_US 100
`define RDL_RXDET_CYC       (`RDL_RXDET_PERIOD_US * `RDL_CLK_MHZ)
`define RDL_U1_IDLE_US      300

`endif

/* File: hdl/rdl_pkg.sv */
// Purpose: Types shared by the redriver control block.
// Assumes: Used together with rdl_params.svh.
// Notes:   Link power states are binary coded.
package rdl_pkg;

	// ------------------------------------------------------------------
	// Link power states
	// ------------------------------------------------------------------
	typedef enum logic [1:0] {
		RDL_DISC = 2'b00,
		RDL_U23  = 2'b01,
		RDL_U1   = 2'b10,
		RDL_U0   = 2'b11
	} rdl_link_t;

	typedef logic [1:0] rdl_level_t;

endpackage

/* File: hdl/rdl_sync.sv */
// Purpose: Two flip-flop synchronizer for pin-level inputs.
// Assumes: Inputs are static levels or slow compared with clk.
// Notes:   The first stage feeds only the second stage.
`timescale 1ns/1ns
`default_nettype none

module rdl_sync #(
	parameter int W = 1
) (
	// Clock and reset
	input  wire logic         clk,
	input  wire logic         nrst,
	input  wire logic         clk_en,
	// Data
	input  wire logic [W-1:0] d,
	output var  logic [W-1:0] q
);

	logic [W-1:0] meta_q;

	// Two stages; a frozen clock enable holds both
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			meta_q <= '0;
			q      <= '0;
		end else if (clk_en) begin
			meta_q <= d;
			q      <= meta_q;
		end
	end

endmodule

`default_nettype wire

/* File: hdl/rdl_ctrl.sv */
// Purpose: Equalization, swing and link power control for a linear
//          redriver with an Avalon-MM register slave.
// Assumes: Analog front end reports strap levels as 2-bit codes and link
//          conditions as levels; all are asynchronous to clk.
// Notes:   Straps are followed live, not latched at power-up.
//
// Implementation choices: the placing of the registers and the Avalon-MM interface to the registers.
`timescale 1ns/1ns
`default_nettype none
`include "rdl_params.svh"

module rdl_ctrl
	import rdl_pkg::*;
#(
	parameter int unsigned U1_IDLE_CYC = `RDL_U1_IDLE_US * `RDL_CLK_MHZ
) (
	// Clock, reset, enable
	input  wire logic        clk,
	input  wire logic        nrst,
	input  wire logic        clk_en,
	// Avalon-MM slave
	input  wire logic [4:0]  avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_writedata,
	input  wire logic [3:0]  avs_byteenable,
	output var  logic [31:0] avs_readdata,
	output logic             avs_waitrequest,
	// Strap pins
	input  wire logic [1:0]  disp_eq_strap_hi,
	input  wire logic [1:0]  disp_eq_strap_lo,
	input  wire logic        usb_enable_strap,
	input  wire logic        reg_mode_strap,
	// Link observations
	input  wire logic        ufp_term_det,
	input  wire logic        dfp_term_det,
	input  wire logic        ufp_eidle,
	input  wire logic        dfp_eidle,
	input  wire logic        lfps_valid,
	input  wire logic        ss_gen2_rate,
	// Receive equalization
	output var  logic [3:0]  disp_lane0_eq_index,
	output var  logic [3:0]  disp_lane1_eq_index,
	output var  logic [3:0]  disp_lane2_eq_index,
	output var  logic [3:0]  disp_lane3_eq_index,
	// Swing and transmit equalization
	output var  logic [1:0]  disp_tx_swing,
	output var  logic [1:0]  usb_dn_tx_swing,
	output var  logic [1:0]  up_linear_swing,
	output var  logic        up_limited_mode,
	output var  logic [1:0]  up_limited_swing,
	output var  logic        tx_preshoot_on,
	output var  logic [1:0]  tx_preshoot_lvl,
	output var  logic        tx_deemphasis_on,
	output var  logic [1:0]  tx_deemphasis_lvl,
	// Link power
	output var  logic [1:0]  link_state,
	output var  logic        redrive_en,
	output var  logic        rx_term_en,
	output var  logic        tx_cm_hold,
	output var  logic        rxdet_req
);

	// ------------------------------------------------------------------
	// Functions
	// ------------------------------------------------------------------

	// Four-level codes 0,R,F,1 are 0..3, so the index is 4*hi+lo
	function automatic logic [3:0] strap_index(input logic [1:0] hi,
	                                           input logic [1:0] lo);
		strap_index = 4'((hi * 4) + lo);
	endfunction

	// Merge write data into a register under byte enables
	function automatic logic [31:0] be_merge(input logic [31:0] old,
	                                         input logic [31:0] wd,
	                                         input logic [3:0]  be);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (be[i]) begin
				r[i*8 +: 8] = wd[i*8 +: 8];
			end
		end
		be_merge = r;
	endfunction

	// ------------------------------------------------------------------
	// Input synchronization
	// ------------------------------------------------------------------
	logic [11:0] sync_q;
	logic [1:0]  s_hi;
	logic [1:0]  s_lo;
	logic        s_usb;
	logic        s_reg;
	logic        s_uterm;
	logic        s_dterm;
	logic        s_uidle;
	logic        s_didle;
	logic        s_lfps;
	logic        s_rate;

	rdl_sync #(.W(12)) u_sync (
		.clk    (clk),
		.nrst   (nrst),
		.clk_en (clk_en),
		.d      ({disp_eq_strap_hi, disp_eq_strap_lo, usb_enable_strap,
		          reg_mode_strap, ufp_term_det, dfp_term_det, ufp_eidle,
		          dfp_eidle, lfps_valid, ss_gen2_rate}),
		.q      (sync_q)
	);

	// Unpack the synchronized vector
	assign {s_hi, s_lo, s_usb, s_reg, s_uterm, s_dterm, s_uidle, s_didle,
	        s_lfps, s_rate} = sync_q;

	// ------------------------------------------------------------------
	// Register bus slave
	// ------------------------------------------------------------------
	logic [4:0]  ctrl_q;
	logic [15:0] eq_q;
	logic [9:0]  swing_q;
	logic        ack_q;
	logic [31:0] status_w;
	logic [31:0] rd_w;
	logic        wr_go;
	logic [31:0] wr_ctrl;
	logic [31:0] wr_eq;
	logic [31:0] wr_swing;
	rdl_link_t   st_q;
	rdl_link_t   st_d;
	logic        usb_en;
	logic        lim_en;

	// One wait cycle per access keeps read data registered
	assign avs_waitrequest = (avs_read || avs_write) && !ack_q;
	assign wr_go           = avs_write && ack_q && clk_en;

	assign wr_ctrl  = be_merge({27'h000_0000, ctrl_q}, avs_writedata,
	                           avs_byteenable);
	assign wr_eq    = be_merge({16'h0000, eq_q}, avs_writedata,
	                           avs_byteenable);
	assign wr_swing = be_merge({22'h00_0000, swing_q}, avs_writedata,
	                           avs_byteenable);

	// Live status: link state, enables, strap index
	always_comb begin
		status_w = 32'h0000_0000;
		status_w[`RDL_ST_LINK_LSB +: 2] = st_q;
		status_w[`RDL_ST_USB_BIT]       = usb_en;
		status_w[`RDL_ST_REGMODE_BIT]   = s_reg;
		status_w[`RDL_ST_RATE_BIT]      = s_rate;
		status_w[`RDL_ST_LIM_BIT]       = up_limited_mode;
		status_w[`RDL_ST_STRAP_LSB +: 4] = strap_index(s_hi, s_lo);
	end

	// Address decode; unmapped words read as zero
	always_comb begin
		unique case (avs_address)
			`RDL_OFS_CTRL:   rd_w = {27'h000_0000, ctrl_q};
			`RDL_OFS_EQ:     rd_w = {16'h0000, eq_q};
			`RDL_OFS_SWING:  rd_w = {22'h00_0000, swing_q};
			`RDL_OFS_STATUS: rd_w = status_w;
			default:         rd_w = 32'h0000_0000;
		endcase
	end

	// Handshake and read data capture
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			ack_q        <= 1'b0;
			avs_readdata <= 32'h0000_0000;
		end else if (clk_en) begin
			ack_q <= (avs_read || avs_write) && !ack_q;
			if (avs_read && !ack_q) begin
				avs_readdata <= rd_w;
			end
		end
	end

	// Writable registers; limited mode resets off
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			ctrl_q  <= `RDL_CTRL_RST;
			eq_q    <= `RDL_EQ_RST;
			swing_q <= `RDL_SW_RST;
		end else if (wr_go) begin
			unique case (avs_address)
				`RDL_OFS_CTRL:  ctrl_q  <= wr_ctrl[4:0];
				`RDL_OFS_EQ:    eq_q    <= wr_eq[15:0];
				`RDL_OFS_SWING: swing_q <= wr_swing[9:0];
				default: ;
			endcase
		end
	end

	// ------------------------------------------------------------------
	// Mode decode
	// ------------------------------------------------------------------
	// Enables are declared with the bus registers, where status reads usb_en

	// USB on by strap pin, or by the config low bit in register mode
	assign usb_en = s_reg ? ctrl_q[`RDL_CTRL_CFG_LSB]
	                      : s_usb;
	// Limited only when register mode selects it
	assign lim_en = s_reg && ctrl_q[`RDL_CTRL_LIM_BIT];

	// ------------------------------------------------------------------
	// Equalization and swing outputs
	// ------------------------------------------------------------------
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			disp_lane0_eq_index <= 4'h0;
			disp_lane1_eq_index <= 4'h0;
			disp_lane2_eq_index <= 4'h0;
			disp_lane3_eq_index <= 4'h0;
		end else if (clk_en) begin
			if (s_reg) begin
				// Per-lane fields
				disp_lane0_eq_index <= eq_q[0*`RDL_EQ_W +: 4];
				disp_lane1_eq_index <= eq_q[1*`RDL_EQ_W +: 4];
				disp_lane2_eq_index <= eq_q[2*`RDL_EQ_W +: 4];
				disp_lane3_eq_index <= eq_q[3*`RDL_EQ_W +: 4];
			end else begin
				// Shared strap pair drives every lane
				disp_lane0_eq_index <= strap_index(s_hi, s_lo);
				disp_lane1_eq_index <= strap_index(s_hi, s_lo);
				disp_lane2_eq_index <= strap_index(s_hi, s_lo);
				disp_lane3_eq_index <= strap_index(s_hi, s_lo);
			end
		end
	end

	// Swing and transmit equalization; downstream is never limited
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			disp_tx_swing     <= `RDL_SWING_LEVEL_THREE;
			usb_dn_tx_swing   <= `RDL_SWING_LEVEL_THREE;
			up_linear_swing   <= `RDL_SWING_LEVEL_THREE;
			up_limited_mode   <= 1'b0;
			up_limited_swing  <= 2'h0;
			tx_preshoot_on    <= 1'b0;
			tx_preshoot_lvl   <= 2'h0;
			tx_deemphasis_on  <= 1'b0;
			tx_deemphasis_lvl <= 2'h0;
		end else if (clk_en) begin
			if (s_reg) begin
				// One field feeds both shared transmitters
				disp_tx_swing   <= swing_q[`RDL_SW_DN_LSB +: 2];
				usb_dn_tx_swing <= swing_q[`RDL_SW_DN_LSB +: 2];
				up_linear_swing <= swing_q[`RDL_SW_UPLIN_LSB +: 2];
			end else begin
				disp_tx_swing   <= `RDL_SWING_LEVEL_THREE;
				usb_dn_tx_swing <= `RDL_SWING_LEVEL_THREE;
				up_linear_swing <= `RDL_SWING_LEVEL_THREE;
			end
			up_limited_mode   <= lim_en;
			up_limited_swing  <= swing_q[`RDL_SW_LIM_LSB +: 2];
			tx_preshoot_lvl   <= swing_q[`RDL_SW_PRE_LSB +: 2];
			tx_deemphasis_lvl <= swing_q[`RDL_SW_DEE_LSB +: 2];
			tx_preshoot_on    <= lim_en && ctrl_q[`RDL_CTRL_PRE_BIT];
			tx_deemphasis_on  <= lim_en && ctrl_q[`RDL_CTRL_DEE_BIT];
		end
	end

	// ------------------------------------------------------------------
	// Link power machine
	// ------------------------------------------------------------------
	logic [15:0] idle_cnt_q;
	logic [11:0] det_cnt_q;
	logic        idle_done;
	logic        det_tick;
	logic        both_term;
	logic        both_idle;

	assign both_term = s_uterm && s_dterm;
	assign both_idle = s_uidle && s_didle;
	assign idle_done = idle_cnt_q == 16'(U1_IDLE_CYC - 1);
	assign det_tick  = det_cnt_q == 12'(`RDL_RXDET_CYC - 1);

	// U1 idle timer, runs only while in U1
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			idle_cnt_q <= 16'h0000;
		end else if (clk_en) begin
			if (st_q != RDL_U1 || idle_done) begin
				idle_cnt_q <= 16'h0000;
			end else begin
				idle_cnt_q <= idle_cnt_q + 16'h0001;
			end
		end
	end

	// Periodic far-end detect timer, runs only in U2/U3
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			det_cnt_q <= 12'h000;
		end else if (clk_en) begin
			if (st_q != RDL_U23 || det_tick) begin
				det_cnt_q <= 12'h000;
			end else begin
				det_cnt_q <= det_cnt_q + 12'h001;
			end
		end
	end

	// Next state from observed link conditions
	always_comb begin
		st_d = st_q;
		if (!usb_en) begin
			st_d = RDL_DISC;
		end else begin
			unique case (st_q)
				RDL_DISC: begin
					if (both_term) begin
						st_d = RDL_U0;
					end
				end
				RDL_U0: begin
					if (both_idle) begin
						st_d = RDL_U1;
					end
				end
				RDL_U1: begin
					if (!both_idle || s_lfps) begin
						st_d = RDL_U0;
					end else if (idle_done) begin
						st_d = RDL_U23;
					end
				end
				RDL_U23: begin
					// Lost termination wins over a coincident LFPS
					if (det_tick && !both_term) begin
						st_d = RDL_DISC;
					end else if (s_lfps) begin
						st_d = RDL_U0;
					end
				end
			endcase
		end
	end

	// State and state-derived outputs move together
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			st_q       <= RDL_DISC;
			link_state <= RDL_DISC;
			redrive_en <= 1'b0;
			rx_term_en <= 1'b0;
			tx_cm_hold <= 1'b0;
			rxdet_req  <= 1'b0;
		end else if (clk_en) begin
			st_q       <= st_d;
			link_state <= st_d;
			redrive_en <= st_d == RDL_U0;
			rx_term_en <= st_d != RDL_DISC;
			tx_cm_hold <= st_d == RDL_U0 || st_d == RDL_U1;
			rxdet_req  <= det_tick && st_q == RDL_U23;
		end
	end

	// ------------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);

	sequence s_disc_ready;
		clk_en && usb_en && st_q == RDL_DISC && both_term;
	endsequence

	sequence s_u0_quiet;
		clk_en && usb_en && st_q == RDL_U0 && both_idle;
	endsequence

	sequence s_u23_wake;
		clk_en && usb_en && st_q == RDL_U23 && s_lfps
		&& !(det_tick && !both_term);
	endsequence

	strap_eq_dec_a: assert property (
		clk_en && !s_reg |=> disp_lane2_eq_index ==
		4'(($past(s_hi) * 4) + $past(s_lo)))
		else $error("strap equalization index wrong");

	reg_eq_lane_a: assert property (
		clk_en && s_reg |=> disp_lane3_eq_index == $past(eq_q[15:12])
		&& disp_lane0_eq_index == $past(eq_q[3:0]))
		else $error("lane equalization field not applied");

	strap_swing_a: assert property (
		clk_en && !s_reg |=> up_linear_swing == `RDL_SWING_LEVEL_THREE
		&& disp_tx_swing == `RDL_SWING_LEVEL_THREE)
		else $error("strap mode swing not level three");

	shared_swing_a: assert property (
		disp_tx_swing == usb_dn_tx_swing)
		else $error("shared transmitters disagree on swing");

	limited_src_a: assert property (
		clk_en && !(s_reg && ctrl_q[`RDL_CTRL_LIM_BIT]) |=> !up_limited_mode)
		else $error("limited mode without register selection");

	preshoot_gate_a: assert property (
		tx_preshoot_on |-> up_limited_mode)
		else $error("pre-shoot on outside limited mode");

	deemph_gate_a: assert property (
		clk_en |=> tx_deemphasis_on == ($past(lim_en)
		&& $past(ctrl_q[`RDL_CTRL_DEE_BIT])))
		else $error("de-emphasis gating wrong");

	disc_exit_a: assert property (
		s_disc_ready |=> st_q == RDL_U0 && redrive_en)
		else $error("no move from disconnect to U0");

	u0_idle_a: assert property (
		s_u0_quiet |=> st_q == RDL_U1 && tx_cm_hold && !redrive_en)
		else $error("no move from U0 to U1");

	lfps_wake_a: assert property (
		s_u23_wake |=> st_q == RDL_U0)
		else $error("LFPS did not wake U2/U3");

	u23_pins_a: assert property (
		st_q == RDL_U23 |-> rx_term_en && !tx_cm_hold)
		else $error("U2/U3 termination or common mode wrong");

	usb_off_a: assert property (
		clk_en && !usb_en |=> st_q == RDL_DISC && !rx_term_en)
		else $error("USB disabled but link not in disconnect");

endmodule

`default_nettype wire

/* File: bench/rdl_far_end.sv */
// Purpose: Far-end link model: host and device ports seen at the pins.
// Assumes: Bench commands attach, idle and wake as levels.
// Notes:   Pins move only just after a rising clk edge.
`timescale 1ns/1ns
`default_nettype none

module rdl_far_end (
	// Clock
	input  wire logic clk,
	// Commands from the bench
	input  wire logic attach,
	input  wire logic idle,
	input  wire logic wake,
	// Link pins
	output var  logic ufp_term,
	output var  logic dfp_term,
	output var  logic ufp_idle,
	output var  logic dfp_idle,
	output var  logic lfps,
	output var  logic rate
);
	// Start detached so the design never sees an unknown pin
	initial begin
		ufp_term = 1'b0;
		dfp_term = 1'b0;
		ufp_idle = 1'b1;
		dfp_idle = 1'b1;
		lfps     = 1'b0;
		rate     = 1'b0;
	end

	// A detached port shows no termination and no signal on its lanes
	always @(posedge clk) begin
		ufp_term <= attach;
		dfp_term <= attach;
		ufp_idle <= ~attach | idle;
		dfp_idle <= ~attach | idle;
		lfps     <= attach & wake;
		rate     <= attach;
	end
endmodule

`default_nettype wire

/* File: bench/redriver_eq_vod_link_power_ctrl_test.sv */
// Purpose: Self-checking bench for rdl_ctrl.
// Assumes: 25 MHz clk, idle timeout shortened to 20 cycles.
// Notes:   Detect interval stays 2500 cycles, so one wait is long.
`timescale 1ns/1ns
`default_nettype none
`include "rdl_params.svh"

module redriver_eq_vod_link_power_ctrl_test;
	import rdl_pkg::*;
	localparam int unsigned IDLE_CYC = 20;
	logic        clk = 1'b0;
	logic        nrst = 1'b0;
	logic [4:0]  adr = 5'h00;
	logic        rd = 1'b0;
	logic        wr = 1'b0;
	logic [31:0] wd = 32'h0000_0000;
	logic [31:0] rdata;
	logic [31:0] rd_q;
	logic        wait_rq;
	logic [1:0]  s_hi = 2'h0;
	logic [1:0]  s_lo = 2'h0;
	logic        usb_s = 1'b0;
	logic        reg_m = 1'b0;
	logic        attach = 1'b0;
	logic        idle = 1'b0;
	logic        wake = 1'b0;
	logic        ut, dt, ue, de, lf, rt;
	logic [3:0]  eq0, eq1, eq2, eq3;
	logic [1:0]  d_sw, u_sw, up_lin, lim_sw, pre_l, dee_l, st;
	logic        lim_m, pre_on, dee_on, rd_en, term, cm, rxdet;
	int          mismatches = 0;
	int          n_tests = 0;

	rdl_ctrl #(.U1_IDLE_CYC(IDLE_CYC)) rdl_ctrl_i (
		.clk(clk), .nrst(nrst), .clk_en(1'b1),
		.avs_address(adr), .avs_read(rd), .avs_write(wr),
		.avs_writedata(wd), .avs_byteenable(4'hF),
		.avs_readdata(rdata), .avs_waitrequest(wait_rq),
		.disp_eq_strap_hi(s_hi), .disp_eq_strap_lo(s_lo),
		.usb_enable_strap(usb_s), .reg_mode_strap(reg_m),
		.ufp_term_det(ut), .dfp_term_det(dt), .ufp_eidle(ue),
		.dfp_eidle(de), .lfps_valid(lf), .ss_gen2_rate(rt),
		.disp_lane0_eq_index(eq0), .disp_lane1_eq_index(eq1),
		.disp_lane2_eq_index(eq2), .disp_lane3_eq_index(eq3),
		.disp_tx_swing(d_sw), .usb_dn_tx_swing(u_sw),
		.up_linear_swing(up_lin), .up_limited_mode(lim_m),
		.up_limited_swing(lim_sw), .tx_preshoot_on(pre_on),
		.tx_preshoot_lvl(pre_l), .tx_deemphasis_on(dee_on),
		.tx_deemphasis_lvl(dee_l), .link_state(st), .redrive_en(rd_en),
		.rx_term_en(term), .tx_cm_hold(cm), .rxdet_req(rxdet)
	);

	rdl_far_end rdl_far_end_i (
		.clk(clk), .attach(attach), .idle(idle), .wake(wake),
		.ufp_term(ut), .dfp_term(dt), .ufp_idle(ue), .dfp_idle(de),
		.lfps(lf), .rate(rt)
	);

	// --------------------------------------------------------------
	// Tasks
	// --------------------------------------------------------------
	task automatic finish_test();
		if (mismatches == 0 && n_tests > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			mismatches++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// One Avalon access; request held until waitrequest is seen low
	task automatic bus(input logic w, input logic [4:0] a,
		input logic [31:0] d);
		@(posedge clk);
		adr <= a;
		wd <= d;
		wr <= w;
		rd <= ~w;
		// No cycle count assumed; only the watchdog ends a hung access
		do begin
			@(posedge clk);
		end while (wait_rq !== 1'b0);
		rd_q = rdata;
		wr <= 1'b0;
		rd <= 1'b0;
	endtask

	// Bounded wait for a link state, then compare it
	task automatic wait_link(input logic [1:0] e, input int max);
		int i;
		for (i = 0; i < max; i++) begin
			@(posedge clk);
			if (st === e) break;
		end
		cmp({30'h0000_0000, st}, {30'h0000_0000, e});
	endtask

	// Free-running clock
	initial begin
		forever #20 clk = ~clk;
	end

	// Watchdog: the long detect wait dominates the run time
	initial begin
		#480000;
		mismatches++;
		finish_test();
	end

	// --------------------------------------------------------------
	// Tests
	// --------------------------------------------------------------
	initial begin
		int h, l, i;
		logic [9:0] v;
		repeat (6) @(posedge clk);
		nrst <= 1'b1;
		cmp({29'h0000_0000, up_lin, lim_m}, 32'h0000_0006);
		bus(1'b0, `RDL_OFS_SWING, 32'h0000_0000);
		cmp(rd_q, 32'h0000_000F);
		bus(1'b0, 5'h10, 32'h0000_0000);
		cmp(rd_q, 32'h0000_0000);
		// Strap mode: refuses limited mode and forces swing level three
		bus(1'b1, `RDL_OFS_CTRL, 32'h0000_001C);
		bus(1'b1, `RDL_OFS_SWING, 32'h0000_0000);
		for (h = 0; h < 4; h++) begin
			for (l = 0; l < 4; l++) begin
				s_hi <= h[1:0];
				s_lo <= l[1:0];
				repeat (5) @(posedge clk);
				cmp({eq3, eq2, eq1, eq0}, {4{h[1:0], l[1:0]}});
			end
		end
		cmp({29'h0000_0000, up_lin, lim_m}, 32'h0000_0006);
		// Register mode: every enable combination and swing code
		reg_m <= 1'b1;
		bus(1'b1, `RDL_OFS_EQ, 32'h0000_F5A0);
		repeat (5) @(posedge clk);
		cmp({eq3, eq2, eq1, eq0}, 32'h0000_F5A0);
		for (i = 0; i < 8; i++) begin
			v = {i[1:0], ~i[1:0], i[1:0], ~i[1:0], i[1:0]};
			bus(1'b1, `RDL_OFS_SWING, {22'h00_0000, v});
			bus(1'b1, `RDL_OFS_CTRL, {27'h000_0000, i[2:0], 2'b11});
			repeat (4) @(posedge clk);
			cmp({dee_l, pre_l, lim_sw, up_lin, d_sw}, v);
			cmp({30'h0000_0000, u_sw}, {30'h0000_0000, v[1:0]});
			cmp({lim_m, pre_on, dee_on}, {i[0], i[0] & i[1], i[0] & i[2]});
		end
		// Link power walk, downstream swing set before the lane change
		bus(1'b1, `RDL_OFS_SWING, 32'h0000_0001);
		bus(1'b1, `RDL_OFS_CTRL, 32'h0000_0001);
		attach <= 1'b1;
		wait_link(RDL_U0, 20);
		cmp({rd_en, term, cm}, 32'h0000_0007);
		// Status: U0, USB on, register mode, rate flag, strap index 15
		bus(1'b0, `RDL_OFS_STATUS, 32'h0000_0000);
		cmp(rd_q, 32'h0000_0F1F);
		idle <= 1'b1;
		wait_link(RDL_U1, 10);
		cmp({rd_en, term, cm}, 32'h0000_0003);
		idle <= 1'b0;
		wait_link(RDL_U0, 10);
		idle <= 1'b1;
		wait_link(RDL_U1, 10);
		repeat (IDLE_CYC / 2) @(posedge clk);
		cmp({30'h0000_0000, st}, {30'h0000_0000, RDL_U1});
		wait_link(RDL_U23, IDLE_CYC + 10);
		cmp({rd_en, term, cm}, 32'h0000_0002);
		wake <= 1'b1;
		wait_link(RDL_U0, 10);
		wake <= 1'b0;
		wait_link(RDL_U1, 10);
		wait_link(RDL_U23, IDLE_CYC + 10);
		attach <= 1'b0;
		wait_link(RDL_DISC, 2600);
		cmp({31'h0000_0000, rxdet}, 32'h0000_0001);
		// Disabling USB drops the link; strap pin enables it again
		attach <= 1'b1;
		wait_link(RDL_U0, 20);
		bus(1'b1, `RDL_OFS_CTRL, 32'h0000_0000);
		wait_link(RDL_DISC, 10);
		reg_m <= 1'b0;
		usb_s <= 1'b1;
		wait_link(RDL_U0, 20);
		// Reset in mid-run drops the link at once; straps bring it back
		nrst <= 1'b0;
		@(posedge clk);
		cmp({30'h0000_0000, st}, {30'h0000_0000, RDL_DISC});
		nrst <= 1'b1;
		wait_link(RDL_U0, 20);
		finish_test();
	end
endmodule

`default_nettype wire
